/* hw/gcd_decoder.sv */
// command decoder: host port, command fifo, parameter ram and command state
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - A command 0111xxxx loads parameter RAM from the low-nibble address with up to 16 following bytes.
// - Command 47h takes one parameter byte as the horizontal pitch in word addresses.
// - Command 22h starts word writes to display memory with the logic operation reset to zero.
// - Command 4Ah takes two bytes as a mask that limits which bits a read-modify-write may change.
// - Command 4Ch accepts up to eleven figure type and drawing parameter bytes.
// - Command 6Ch moves drawing parameters from parameter RAM to the drawing processor and starts at the cursor.
// - Command 68h starts pattern drawing or area fill from parameter RAM at the cursor.
// - Command A0h reads display memory words to the host, low byte before high byte.
// - Command E0h returns the cursor word and dot address to the host as five bytes.
// - Command A4h starts a word DMA read request, low byte first.
// - Command 24h starts a word DMA write request, low byte first, replacing the addressed word.
// - The host port carries commands and data in and status, cursor bytes and memory word bytes out.
// - Every write goes to the fifo unless it is full, select low for command and high for parameter; a read low is data, high is status.
// - Incoming bytes are buffered in a sixteen byte fifo ahead of decoding.
// - Sixteen bytes of parameter RAM hold parameters reused during drawing.
module gcd_decoder #(
   parameter int FIFO_DEPTH = gcd_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // host port
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic port_select_bit,
   input wire logic [7:0] host_wdata,
   output logic [7:0] host_rdata,
   output logic host_wr_ready,
   // display memory side
   input wire logic [15:0] mem_rdata,
   input wire logic mem_rvalid,
   output logic mem_read_req,
   output logic mem_write_mode,
   output logic [1:0] read_modify_write,
   output logic [15:0] write_mask,
   output logic [7:0] pitch,
   // drawing processor
   output logic figure_draw,
   output logic pattern_draw_fill,
   output logic [3:0] draw_param_addr,
   output logic [7:0] draw_param_data,
   output logic [87:0] figure_setup,
   input wire logic draw_busy,
   // cursor and dma
   input wire logic [23:0] cursor_word_addr,
   input wire logic [3:0] cursor_dot_addr,
   output logic dma_read_request,
   output logic dma_write_request
);
   initial begin
      if (FIFO_DEPTH != gcd_pkg::FIFO_DEPTH) begin
         $error("gcd_decoder: command fifo must hold sixteen entries");
      end
   end
   typedef enum {GCD_IDLE, GCD_RAM_LOAD, GCD_PITCH, GCD_MASK, GCD_FIG_SETUP, GCD_DRAIN} gcd_state_t;

   //////////////////////////////////////////////////////////////////////////
   // command fifo: bit 8 marks a parameter byte
   logic f_valid;
   logic f_ready;
   logic [8:0] f_data;
   logic f_empty;
   logic f_full;
   logic in_ready;
   logic push;
   assign push = host_wr;
   gcd_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(push),
      .in_ready(in_ready),
      .in_data({port_select_bit, host_wdata}),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_data),
      .empty(f_empty),
      .full(f_full)
   );
   // drawing holds off decoding so the fifo really fills
   assign f_ready = !draw_busy;

   logic is_param;
   logic [7:0] byte_v;
   logic take;
   assign is_param = f_data[8];
   assign byte_v = f_data[7:0];
   assign take = f_valid && f_ready;

   //////////////////////////////////////////////////////////////////////////
   // parameter ram
   logic param_ram_load_we;
   logic [3:0] param_ram_load_wa;
   logic [3:0] param_ram_load_ra_r;
   logic [7:0] param_ram_load_rd;
   gcd_param_ram_load #(.DEPTH(gcd_pkg::RAM_DEPTH)) u_param_ram_load (
      .clk(clk),
      .wr_en(param_ram_load_we),
      .wr_addr(param_ram_load_wa),
      .wr_data(byte_v),
      .rd_addr(param_ram_load_ra_r),
      .rd_data(param_ram_load_rd)
   );

   //////////////////////////////////////////////////////////////////////////
   // decode state
   gcd_state_t state_r;
   logic [4:0] pcnt_r;
   logic [3:0] paddr_r;
   assign param_ram_load_we = take && is_param && (state_r == GCD_RAM_LOAD) && (pcnt_r < gcd_pkg::CNT_RAM_LOAD);
   assign param_ram_load_wa = paddr_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= GCD_IDLE;
         pcnt_r <= 5'h00;
         paddr_r <= 4'h0;
      end else if (take) begin
         if (!is_param) begin
            pcnt_r <= 5'h00;
            paddr_r <= byte_v[3:0];
            if (byte_v[7:4] == gcd_pkg::OP_RAM_LOAD_HI) begin
               state_r <= GCD_RAM_LOAD;
            end else if (byte_v == gcd_pkg::OP_PITCH) begin
               state_r <= GCD_PITCH;
            end else if (byte_v == gcd_pkg::OP_MASK) begin
               state_r <= GCD_MASK;
            end else if (byte_v == gcd_pkg::OP_FIG_SETUP) begin
               state_r <= GCD_FIG_SETUP;
            end else begin
               state_r <= GCD_DRAIN;
            end
         end else begin
            pcnt_r <= (pcnt_r == 5'h1F) ? pcnt_r : pcnt_r + 5'h01;
            paddr_r <= paddr_r + 4'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pitch <= gcd_pkg::PITCH_RESET;
      end else if (take && is_param && state_r == GCD_PITCH && pcnt_r < gcd_pkg::CNT_PITCH) begin
         pitch <= byte_v;
      end
   end

   // mask low byte then high byte
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         write_mask <= gcd_pkg::MASK_RESET;
      end else if (take && is_param && state_r == GCD_MASK && pcnt_r < gcd_pkg::CNT_MASK) begin
         if (pcnt_r == 5'h00) begin
            write_mask[7:0] <= byte_v;
         end else begin
            write_mask[15:8] <= byte_v;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         figure_setup <= '0;
      end else if (take && is_param && state_r == GCD_FIG_SETUP && pcnt_r < gcd_pkg::CNT_FIG_SETUP) begin
         figure_setup[pcnt_r[3:0]*8 +: 8] <= byte_v;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // one-shot commands and modes
   logic cmd_take;
   assign cmd_take = take && !is_param;
   logic [2:0] cursor_read_left_r;
   logic [39:0] cursor_read_sh_r;
   logic [7:0] rd_hi_r;
   logic rd_hi_pend_r;
   logic rd_word_active_r;
   logic [7:0] lo_r;
   logic lo_pend_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         figure_draw <= 1'b0;
         pattern_draw_fill <= 1'b0;
         mem_write_mode <= 1'b0;
         read_modify_write <= gcd_pkg::OPER_REPLACE;
         dma_read_request <= 1'b0;
         dma_write_request <= 1'b0;
         mem_read_req <= 1'b0;
      end else begin
         figure_draw <= cmd_take && byte_v == gcd_pkg::OP_FIG_DRAW;
         pattern_draw_fill <= cmd_take && byte_v == gcd_pkg::OP_PAT_FILL;
         mem_read_req <= cmd_take && byte_v == gcd_pkg::OP_MEM_READ;
         dma_read_request <= cmd_take && byte_v == gcd_pkg::OP_DMA_READ;
         dma_write_request <= cmd_take && byte_v == gcd_pkg::OP_DMA_WRITE;
         if (cmd_take && byte_v == gcd_pkg::OP_MEM_WRITE) begin
            mem_write_mode <= 1'b1;
            read_modify_write <= gcd_pkg::OPER_RESET;
         end else if (cmd_take && byte_v == gcd_pkg::OP_DMA_WRITE) begin
            mem_write_mode <= 1'b1;
            read_modify_write <= gcd_pkg::OPER_REPLACE;
         end else if (cmd_take) begin
            mem_write_mode <= 1'b0;
         end
      end
   end

   // drawing processor reads parameter ram one byte per cycle from 0
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         param_ram_load_ra_r <= 4'h0;
         draw_param_addr <= 4'h0;
         draw_param_data <= 8'h00;
      end else begin
         param_ram_load_ra_r <= (figure_draw || pattern_draw_fill) ? 4'h0 : param_ram_load_ra_r + 4'h1;
         draw_param_addr <= param_ram_load_ra_r;
         draw_param_data <= param_ram_load_rd;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // host read-back: cursor bytes, memory word bytes
   logic host_rd_data;
   assign host_rd_data = host_rd && !port_select_bit;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cursor_read_left_r <= 3'h0;
         cursor_read_sh_r <= '0;
         rd_hi_r <= 8'h00;
         rd_hi_pend_r <= 1'b0;
         rd_word_active_r <= 1'b0;
      end else begin
         if (cmd_take && byte_v == gcd_pkg::OP_CURSOR_READ) begin
            cursor_read_left_r <= gcd_pkg::CURSOR_BYTES;
            cursor_read_sh_r <= {4'h0, cursor_dot_addr, 4'h0, cursor_dot_addr, cursor_word_addr};
         end else if (host_rd_data && cursor_read_left_r != 3'h0) begin
            cursor_read_left_r <= cursor_read_left_r - 3'h1;
            cursor_read_sh_r <= {8'h00, cursor_read_sh_r[39:8]};
         end
         if (cmd_take) begin
            rd_word_active_r <= byte_v == gcd_pkg::OP_MEM_READ;
         end
         // low byte then high byte
         // the high byte stays pending until the low byte has been popped
         if (mem_rvalid && rd_word_active_r) begin
            rd_hi_r <= mem_rdata[15:8];
            rd_hi_pend_r <= 1'b1;
         end else if (host_rd_data && cursor_read_left_r == 3'h0 && !lo_pend_r && rd_hi_pend_r) begin
            rd_hi_pend_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lo_r <= 8'h00;
         lo_pend_r <= 1'b0;
      end else if (mem_rvalid && rd_word_active_r) begin
         lo_r <= mem_rdata[7:0];
         lo_pend_r <= 1'b1;
      end else if (host_rd_data && cursor_read_left_r == 3'h0 && lo_pend_r) begin
         lo_pend_r <= 1'b0;
      end
   end

   // status and data back to host
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         host_rdata <= 8'h00;
         host_wr_ready <= 1'b0;
      end else begin
         host_wr_ready <= in_ready && !(push && f_full);
         if (port_select_bit) begin
            host_rdata <= {3'h0, dma_read_request || dma_write_request, draw_busy,
               f_empty, f_full, lo_pend_r || rd_hi_pend_r || cursor_read_left_r != 3'h0};
         end else if (cursor_read_left_r != 3'h0) begin
            host_rdata <= cursor_read_sh_r[7:0];
         end else if (lo_pend_r) begin
            host_rdata <= lo_r;
         end else begin
            host_rdata <= rd_hi_r;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // checks
   a_pitch_load: assert property (@(posedge clk) disable iff (!rst_n)
      (take && is_param && state_r == GCD_PITCH && pcnt_r == 5'h00) |=> pitch == $past(byte_v))
      else $error("pitch not loaded from first parameter");
   a_pitch_extra: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == GCD_PITCH && pcnt_r != 5'h00) |=> $stable(pitch))
      else $error("extra pitch parameter changed pitch");
   a_new_cmd_reset: assert property (@(posedge clk) disable iff (!rst_n)
      cmd_take |=> pcnt_r == 5'h00)
      else $error("command did not restart parameter count");
   a_param_ram_load_state: assert property (@(posedge clk) disable iff (!rst_n)
      (cmd_take && byte_v[7:4] == 4'h7) |=> state_r == GCD_RAM_LOAD && paddr_r == $past(byte_v[3:0]))
      else $error("ram load not entered at nibble address");
   a_param_ram_load_limit: assert property (@(posedge clk) disable iff (!rst_n)
      param_ram_load_we |-> pcnt_r < 5'h10)
      else $error("more than sixteen ram bytes written");
   a_memory_write_cmd_mode: assert property (@(posedge clk) disable iff (!rst_n)
      (cmd_take && byte_v == 8'h22) |=> mem_write_mode && read_modify_write == 2'h2)
      else $error("write command not in reset operation");
   a_mask_hi: assert property (@(posedge clk) disable iff (!rst_n)
      (take && is_param && state_r == GCD_MASK && pcnt_r == 5'h01) |=> write_mask[15:8] == $past(byte_v))
      else $error("mask high byte not loaded");
   a_figure_draw_pulse: assert property (@(posedge clk) disable iff (!rst_n)
      (cmd_take && byte_v == 8'h6C) |=> figure_draw ##1 !figure_draw)
      else $error("draw start not a single pulse");
   a_dma_pulse: assert property (@(posedge clk) disable iff (!rst_n)
      (cmd_take && byte_v == 8'hA4) |=> dma_read_request && !dma_write_request)
      else $error("dma read request missing");
   a_cursor_read_count: assert property (@(posedge clk) disable iff (!rst_n)
      (cmd_take && byte_v == 8'hE0) |=> cursor_read_left_r == 3'h5)
      else $error("cursor read not five bytes");
endmodule

/* hw/gcd_fifo.sv */
// byte fifo holding commands and parameters ahead of the decoder
`timescale 1ns/1ps
module gcd_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // state
   output logic empty,
   output logic full
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
         $error("gcd_fifo: depth must be a power of two of at least 2");
      end
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wp_r;
   logic [AW:0] rp_r;
   logic do_wr;
   logic do_rd;
   assign empty = (wp_r == rp_r);
   assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[rp_r[AW-1:0]];
   assign do_wr = in_valid && !full;
   assign do_rd = out_ready && !empty;
   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wp_r[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         if (do_wr) begin
            wp_r <= wp_r + 1'b1;
         end
         if (do_rd) begin
            rp_r <= rp_r + 1'b1;
         end
      end
   end
   a_fifo_no_overrun: assert property (@(posedge clk) disable iff (!rst_n)
      full |=> (wp_r == $past(wp_r)))
      else $error("fifo pointer moved while full");
endmodule

/* hw/gcd_param_ram_load.sv */
// sixteen byte parameter ram with one write and one read port
`timescale 1ns/1ps
module gcd_param_ram_load #(
   parameter int DEPTH = 16
) (
   // clock
   input wire logic clk,
   // write port
   input wire logic wr_en,
   input wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input wire logic [7:0] wr_data,
   // read port
   input wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic [7:0] rd_data
);
   initial begin
      if (DEPTH < 2) begin
         $error("gcd_param_ram_load: depth too small");
      end
   end
   logic [7:0] mem [DEPTH];
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end
   assign rd_data = mem[rd_addr];
endmodule

/* hw/gcd_pkg.sv */
// constants for the graphics command decoder
package gcd_pkg;
   // command opcodes
   localparam logic [3:0] OP_RAM_LOAD_HI = 4'h7;
   localparam logic [7:0] OP_PITCH = 8'h47;
   localparam logic [7:0] OP_MEM_WRITE = 8'h22;
   localparam logic [7:0] OP_MASK = 8'h4A;
   localparam logic [7:0] OP_FIG_SETUP = 8'h4C;
   localparam logic [7:0] OP_FIG_DRAW = 8'h6C;
   localparam logic [7:0] OP_PAT_FILL = 8'h68;
   localparam logic [7:0] OP_MEM_READ = 8'hA0;
   localparam logic [7:0] OP_CURSOR_READ = 8'hE0;
   localparam logic [7:0] OP_DMA_READ = 8'hA4;
   localparam logic [7:0] OP_DMA_WRITE = 8'h24;
   // parameter counts
   localparam logic [4:0] CNT_RAM_LOAD = 5'h10;
   localparam logic [4:0] CNT_PITCH = 5'h01;
   localparam logic [4:0] CNT_MASK = 5'h02;
   localparam logic [4:0] CNT_FIG_SETUP = 5'h0B;
   localparam logic [2:0] CURSOR_BYTES = 3'h5;
   // sizes
   localparam int FIFO_DEPTH = 16;
   localparam int RAM_DEPTH = 16;
   localparam int FIG_DEPTH = 11;
   // read-modify-write operations
   localparam logic [1:0] OPER_REPLACE = 2'h0;
   localparam logic [1:0] OPER_RESET = 2'h2;
   // status bit positions
   localparam int ST_FIFO_EMPTY = 2;
   localparam int ST_FIFO_FULL = 1;
   localparam int ST_DRAWING = 3;
   localparam int ST_DMA = 4;
   localparam int ST_RDATA_READY = 0;
   // reset values
   localparam logic [15:0] MASK_RESET = 16'hFFFF;
   localparam logic [7:0] PITCH_RESET = 8'h00;
endpackage

/* tb/gcd_decoder_test.sv */
// self-checking bench for the graphics command decoder
`timescale 1ns/1ps
module gcd_decoder_test;
   logic clk, rst_n, host_wr, host_rd, port_select_bit, host_wr_ready;
   logic [7:0] host_wdata, host_rdata, pitch, draw_param_data, p1, b;
   logic [15:0] mem_rdata, write_mask, next_word;
   logic mem_rvalid, mem_read_req, mem_write_mode, figure_draw, pattern_draw_fill;
   logic draw_busy, dma_read_request, dma_write_request, hold;
   logic [1:0] read_modify_write, lat;
   logic [3:0] draw_param_addr, cursor_dot_addr;
   logic [87:0] figure_setup, fig_m;
   logic [23:0] cursor_word_addr;
   logic [7:0] ram_m [16];
   logic [7:0] pq [$];
   logic [7:0] cb [5];
   int failures, check_count, cyc, i;
   int n_fd, n_pf, n_mr, n_dr, n_dw;
   int seed = 32'h1117d53d;
   gcd_decoder dut_u (.clk, .rst_n, .host_wr, .host_rd, .port_select_bit, .host_wdata, .host_rdata,
      .host_wr_ready, .mem_rdata, .mem_rvalid, .mem_read_req, .mem_write_mode, .read_modify_write,
      .write_mask, .pitch, .figure_draw, .pattern_draw_fill, .draw_param_addr, .draw_param_data,
      .figure_setup, .draw_busy, .cursor_word_addr, .cursor_dot_addr, .dma_read_request,
      .dma_write_request);
   gcd_mem_model mem_u (.clk, .rst_n, .mem_read_req, .figure_draw, .pattern_draw_fill, .next_word,
      .lat, .hold, .mem_rdata, .mem_rvalid, .draw_busy);
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // pulses are one cycle wide, so count them at every edge
   always @(posedge clk) begin
      cyc++;
      if (figure_draw === 1'b1) n_fd++;
      if (pattern_draw_fill === 1'b1) n_pf++;
      if (mem_read_req === 1'b1) n_mr++;
      if (dma_read_request === 1'b1) n_dr++;
      if (dma_write_request === 1'b1) n_dw++;
      if (cyc == 20000) begin
         failures++;
         close_out;
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("checks %0d errors %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string what, input logic [87:0] exp, input logic [87:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_n(input string what, input int exp, input int got);
      check_count++;
      if (got != exp) begin
         failures++;
         $display("Error %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   task automatic wr(input logic sel, input logic [7:0] d);
      @(posedge clk);
      #1 host_wr = 1'b1;
      port_select_bit = sel;
      host_wdata = d;
      @(posedge clk);
      #1 host_wr = 1'b0;
   endtask
   // command followed by n random parameters, kept in pq
   task automatic send(input logic [7:0] op, input int n);
      logic [7:0] p;
      wr(1'b0, op);
      pq.delete();
      for (int k = 0; k < n; k++) begin
         p = 8'($random(seed));
         pq.push_back(p);
         wr(1'b1, p);
      end
   endtask
   // wait on the status byte until the fifo is drained and drawing is idle
   task automatic settle;
      int k;
      @(posedge clk);
      #1 port_select_bit = 1'b1;
      repeat (4) @(posedge clk);
      #1 k = 0;
      while ((host_rdata[gcd_pkg::ST_FIFO_EMPTY] !== 1'b1 || draw_busy !== 1'b0) && k < 300) begin
         @(posedge clk);
         #1 k++;
      end
      chk_n("settle", 1, int'(k < 300)); // drained in time
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic rdb(output logic [7:0] d);
      @(posedge clk);
      #1 port_select_bit = 1'b0;
      repeat (2) @(posedge clk);
      #1 d = host_rdata;
      host_rd = 1'b1;
      @(posedge clk);
      #1 host_rd = 1'b0;
   endtask
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      host_wr = 1'b0;
      host_rd = 1'b0;
      port_select_bit = 1'b0;
      host_wdata = 8'h00;
      hold = 1'b0;
      lat = 2'h1;
      next_word = 16'h0000;
      cursor_word_addr = 24'($random(seed));
      cursor_dot_addr = 4'($random(seed));
      rst_n = 1'b0;
      repeat (6) @(posedge clk);
      #1 rst_n = 1'b1;
      @(posedge clk);
      #1;
      chk("pitch", gcd_pkg::PITCH_RESET, pitch); // reset value
      chk("mask", gcd_pkg::MASK_RESET, write_mask); // reset value
      chk("mode", 1'b0, mem_write_mode); // reset value
      chk("figure", 88'h0, figure_setup); // reset value
      send(gcd_pkg::OP_PITCH, 3);
      settle;
      p1 = pq[0];
      chk("pitch", p1, pitch); // first byte only
      send(8'hFE, 2);
      settle;
      chk("pitch", p1, pitch); // unknown command
      send(gcd_pkg::OP_MASK, 2);
      settle;
      chk("mask", {pq[1], pq[0]}, write_mask); // low then high
      send(gcd_pkg::OP_FIG_SETUP, 12);
      for (i = 0; i < 11; i++) fig_m[8*i +: 8] = pq[i];
      settle;
      chk("figure", fig_m, figure_setup); // eleven bytes
      send(gcd_pkg::OP_FIG_SETUP, 3);
      for (i = 0; i < 3; i++) fig_m[8*i +: 8] = pq[i];
      send(gcd_pkg::OP_PITCH, 1);
      settle;
      chk("figure", fig_m, figure_setup); // short list
      chk("pitch", pq[0], pitch); // next command
      send(gcd_pkg::OP_MEM_WRITE, 0);
      settle;
      chk("mode", 1'b1, mem_write_mode); // word write
      chk("logic op", gcd_pkg::OPER_RESET, read_modify_write); // reset op
      send(gcd_pkg::OP_DMA_WRITE, 0);
      settle;
      chk("logic op", gcd_pkg::OPER_REPLACE, read_modify_write); // replace op
      chk_n("dma write", 1, n_dw); // request
      send(gcd_pkg::OP_DMA_READ, 0);
      settle;
      chk_n("dma read", 1, n_dr); // request
      chk("mode", 1'b0, mem_write_mode); // read leaves write mode
      send({gcd_pkg::OP_RAM_LOAD_HI, 4'h3}, 17);
      for (i = 0; i < 16; i++) ram_m[(3 + i) % 16] = pq[i];
      send({gcd_pkg::OP_RAM_LOAD_HI, 4'hA}, 2);
      ram_m[10] = pq[0];
      ram_m[11] = pq[1];
      // the pitch command waits in the fifo while drawing stalls it, then loads once drawing ends
      send(gcd_pkg::OP_FIG_DRAW, 0);
      send(gcd_pkg::OP_PITCH, 1);
      settle;
      chk_n("draw start", 1, n_fd); // draw start
      chk("pitch", pq[0], pitch); // stalled order
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         #1 chk("ram", ram_m[draw_param_addr], draw_param_data); // ram contents
      end
      send(gcd_pkg::OP_PAT_FILL, 0);
      settle;
      chk_n("fill", 1, n_pf); // pattern start
      for (i = 0; i < 2; i++) begin
         lat = 2'(3 * i);
         next_word = 16'($random(seed));
         send(gcd_pkg::OP_MEM_READ, 0);
         settle;
         repeat (8) @(posedge clk);
         rdb(b);
         chk("mem lo", next_word[7:0], b); // low first
         @(posedge clk);
         #1 port_select_bit = 1'b1;
         repeat (2) @(posedge clk);
         #1 chk("data ready", 1'b1, host_rdata[gcd_pkg::ST_RDATA_READY]); // high byte pending
         rdb(b);
         chk("mem hi", next_word[15:8], b); // high second
      end
      chk_n("memrd", 2, n_mr); // read requests
      cb = '{cursor_word_addr[7:0], cursor_word_addr[15:8], cursor_word_addr[23:16],
         {4'h0, cursor_dot_addr}, {4'h0, cursor_dot_addr}};
      send(gcd_pkg::OP_CURSOR_READ, 0);
      settle;
      for (i = 0; i < gcd_pkg::CURSOR_BYTES; i++) begin
         rdb(b);
         chk("cursor", cb[i], b); // five bytes
      end
      settle;
      chk("status", 2'b10, host_rdata[2:1]); // empty status
      hold = 1'b1;
      p1 = 8'($random(seed));
      wr(1'b0, gcd_pkg::OP_PITCH);
      wr(1'b1, p1);
      for (i = 0; i < 13; i++) wr(1'b1, 8'($random(seed)));
      repeat (2) @(posedge clk);
      #1 chk("ready", 1'b1, host_wr_ready); // fifteen held
      wr(1'b1, 8'h5A);
      repeat (2) @(posedge clk);
      #1 chk("ready", 1'b0, host_wr_ready); // sixteen held
      port_select_bit = 1'b1;
      repeat (2) @(posedge clk);
      #1 chk("full", 1'b1, host_rdata[gcd_pkg::ST_FIFO_FULL]); // full status
      wr(1'b0, gcd_pkg::OP_PITCH);
      wr(1'b1, ~p1);
      hold = 1'b0;
      settle;
      chk("pitch", p1, pitch); // dropped when full
      close_out;
   end
endmodule

/* tb/gcd_mem_model.sv */
// display memory and drawing engine stand-in for the decoder bench
`timescale 1ns/1ps
module gcd_mem_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // decoder requests
   input wire logic mem_read_req,
   input wire logic figure_draw,
   input wire logic pattern_draw_fill,
   // bench controls
   input wire logic [15:0] next_word,
   input wire logic [1:0] lat,
   input wire logic hold,
   // answers
   output logic [15:0] mem_rdata,
   output logic mem_rvalid,
   output logic draw_busy
);
   int wait_c;
   int busy_c;
   //////////////////////////////////////////////////////////////////////////////
   // word per request
   // data flips every idle cycle so a late capture never sees a valid word
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_c <= 0;
         mem_rvalid <= 1'b0;
         mem_rdata <= 16'h0000;
      end else begin
         mem_rvalid <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_read_req) begin
            wait_c <= int'(lat) + 1;
         end else if (wait_c == 1) begin
            mem_rvalid <= 1'b1;
            mem_rdata <= next_word;
            wait_c <= 0;
         end else if (wait_c > 1) begin
            wait_c <= wait_c - 1;
         end
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   // busy after start
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_c <= 0;
      end else if (figure_draw || pattern_draw_fill) begin
         busy_c <= 6;
      end else if (busy_c > 0) begin
         busy_c <= busy_c - 1;
      end
   end
   assign draw_busy = hold || (busy_c != 0);
endmodule
